// File: logic/latch_speed_point_ctrl.sv
// Latch-corrected speed-point positioning control for one axis.
`timescale 1ns/1ps

// Functional notes
// - On request the block prepares, then enters the latch-wait state.
// - Speed segment runs at target speed until its trigger, then continues.
// - Amplifier latch during an active speed table triggers the end-point table.
// - Latched amplifier position is captured and offered for correction.
// - Ordinary speed-point start contact is ignored while the function is active.
// - Following positioning starts one millisecond after the latch is detected.
// - Second latch within one operation gives error 16#3070 and error stop.
// - Actual speed and torque monitor values are withheld meanwhile.
module latch_speed_point_ctrl
   import latch_pt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic latch_req_i,
   input wire logic op_start_i,
   input wire logic op_done_i,
   input wire table_s table_i,
   input wire logic start_contact_i,
   input wire latch_evt_s amp_latch_i,
   input wire logic [POS_W-1:0] mon_speed_i,
   input wire logic [POS_W-1:0] mon_torque_i,
   output logic latch_wait_o,
   output logic armed_o,
   output logic next_table_o,
   output logic [POS_W-1:0] latch_pos_o,
   output logic latch_pos_valid_o,
   output logic error_stop_o,
   output logic [15:0] error_code_o,
   output logic [POS_W-1:0] mon_speed_o,
   output logic [POS_W-1:0] mon_torque_o,
   output logic mon_valid_o
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PREP,
      ST_WAIT,
      ST_DELAY,
      ST_USED,
      ST_ERROR
   } state_e;

   state_e state_reg, state_next;
   logic next_table_reg;
   logic [POS_W-1:0] latch_pos_reg;
   logic latch_pos_valid_reg;
   logic error_stop_reg;
   logic [15:0] error_code_reg;
   logic [POS_W-1:0] mon_speed_reg;
   logic [POS_W-1:0] mon_torque_reg;
   logic mon_valid_reg;
   logic delay_fire;
   logic next_table_next;
   logic [POS_W-1:0] latch_pos_next;
   logic latch_pos_valid_next;
   logic error_stop_next;
   logic [15:0] error_code_next;
   logic [POS_W-1:0] mon_speed_next;
   logic [POS_W-1:0] mon_torque_next;
   logic mon_valid_next;
   logic latch_wait_next;
   logic armed_next;
   logic latch_wait_reg;
   logic armed_reg;

   wire armed_w = (state_reg != ST_IDLE);
   wire speed_tbl_w = table_i.active && (table_i.pattern == PAT_SPEED);
   wire latch_hit_w = amp_latch_i.valid && speed_tbl_w;
   // Once one latch is taken, any further latch in the operation is a fault.
   wire second_w = amp_latch_i.valid &&
                   ((state_reg == ST_DELAY) || (state_reg == ST_USED));
   wire arm_delay_w = (state_reg == ST_WAIT) && latch_hit_w;
   // With the function armed the plain contact never triggers the table.
   wire contact_trig_w = !armed_w && speed_tbl_w && start_contact_i;
   wire hide_mon_w = armed_w && speed_tbl_w;

   // Flow: request, one preparation cycle, then wait for the amplifier latch.
   // A latch starts the fixed delay; the used state holds until the program
   // ends or restarts the operation, and a second latch locks the error.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (latch_req_i) begin
               state_next = ST_PREP;
            end
         end
         ST_PREP: begin
            state_next = ST_WAIT;
         end
         ST_WAIT: begin
            if (latch_hit_w) begin
               state_next = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (second_w) begin
               state_next = ST_ERROR;
            end else if (delay_fire) begin
               state_next = ST_USED;
            end
         end
         ST_USED: begin
            if (second_w) begin
               state_next = ST_ERROR;
            end else if (op_done_i || op_start_i) begin
               state_next = ST_WAIT;
            end
         end
         ST_ERROR: begin
            if (op_start_i) begin
               state_next = ST_WAIT;
            end
         end
      endcase
      // Dropping the request always wins, even in the error state.
      if (!latch_req_i) begin
         state_next = ST_IDLE;
      end
   end

   // A second latch or a dropped request stops the count, so no late start.
   start_delay u_delay (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .arm_i(arm_delay_w),
      .cancel_i(!latch_req_i || second_w),
      .busy_o(),
      .fire_o(delay_fire)
   );

   // Without the function, the contact advances the table at once.
   assign next_table_next = delay_fire || contact_trig_w;
   // A capture beats an operation start in the same cycle.
   assign latch_pos_next = arm_delay_w ? amp_latch_i.position :
      latch_pos_reg;
   assign latch_pos_valid_next = arm_delay_w ? 1'b1 :
      (op_start_i ? 1'b0 : latch_pos_valid_reg);
   // The fault beats an operation start in the same cycle, so it is kept.
   assign error_stop_next = second_w ? 1'b1 :
      (op_start_i ? 1'b0 : error_stop_reg);
   assign error_code_next = second_w ? ERR_MULTI_LATCH :
      (op_start_i ? ERR_NONE : error_code_reg);
   // Withheld monitor words read zero so stale values are never mistaken.
   assign mon_speed_next = hide_mon_w ? POS_RESET : mon_speed_i;
   assign mon_torque_next = hide_mon_w ? POS_RESET : mon_torque_i;
   assign mon_valid_next = !hide_mon_w;
   // Status flags follow the next state so they line up with the state.
   assign latch_wait_next = (state_next == ST_WAIT);
   assign armed_next = (state_next != ST_IDLE);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         next_table_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         next_table_reg <= next_table_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         latch_pos_reg <= POS_RESET;
         latch_pos_valid_reg <= 1'b0;
      end else begin
         latch_pos_reg <= latch_pos_next;
         latch_pos_valid_reg <= latch_pos_valid_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         error_stop_reg <= 1'b0;
         error_code_reg <= ERR_NONE;
      end else begin
         error_stop_reg <= error_stop_next;
         error_code_reg <= error_code_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mon_speed_reg <= POS_RESET;
         mon_torque_reg <= POS_RESET;
         mon_valid_reg <= 1'b0;
      end else begin
         mon_speed_reg <= mon_speed_next;
         mon_torque_reg <= mon_torque_next;
         mon_valid_reg <= mon_valid_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         latch_wait_reg <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         latch_wait_reg <= latch_wait_next;
         armed_reg <= armed_next;
      end
   end

   assign latch_wait_o = latch_wait_reg;
   assign armed_o = armed_reg;
   assign next_table_o = next_table_reg;
   assign latch_pos_o = latch_pos_reg;
   assign latch_pos_valid_o = latch_pos_valid_reg;
   assign error_stop_o = error_stop_reg;
   assign error_code_o = error_code_reg;
   assign mon_speed_o = mon_speed_reg;
   assign mon_torque_o = mon_torque_reg;
   assign mon_valid_o = mon_valid_reg;
endmodule : latch_speed_point_ctrl

// File: include/latch_pt_pkg.sv
// Package of constants and carriers for the latch-corrected speed-point control.
package latch_pt_pkg;
   localparam int CLK_FREQ_HZ = 40000000;
   localparam int START_DELAY_US = 1000;
   localparam int START_DELAY_CYC = (CLK_FREQ_HZ / 1000000) * START_DELAY_US;
   localparam int DELAY_W = 16;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_MULTI_LATCH = 16'h3070;
   localparam int POS_W = 32;
   localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;

   typedef enum logic [1:0] {
      PAT_END,
      PAT_SPEED,
      PAT_OTHER
   } pattern_e;

   typedef struct packed {
      logic valid;
      logic [POS_W-1:0] position;
   } latch_evt_s;

   typedef struct packed {
      logic active;
      pattern_e pattern;
   } table_s;
endpackage : latch_pt_pkg

// File: logic/start_delay.sv
// Delay counter that issues one start pulse a fixed time after arming.
`timescale 1ns/1ps
module start_delay
   import latch_pt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic arm_i,
   input wire logic cancel_i,
   output logic busy_o,
   output logic fire_o
);
   logic [DELAY_W-1:0] count_reg;
   logic busy_reg;
   logic fire_reg;
   logic last_w;

   // The owner registers the fire pulse once more, so the count stops one
   // cycle short and the visible start lands a whole delay after arming.
   assign last_w = (count_reg == DELAY_W'(START_DELAY_CYC - 2));

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || cancel_i) begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         fire_reg <= 1'b0;
      end else begin
         fire_reg <= busy_reg && last_w;
         if (arm_i && !busy_reg) begin
            busy_reg <= 1'b1;
            count_reg <= '0;
         end else if (busy_reg) begin
            busy_reg <= !last_w;
            count_reg <= count_reg + DELAY_W'(1);
         end
      end
   end

   assign busy_o = busy_reg;
   assign fire_o = fire_reg;
endmodule : start_delay

// File: sim/latch_pt_checker.sv
// Port checker for the latch-corrected speed-point control.
`timescale 1ns/1ps
module latch_pt_checker
   import latch_pt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic latch_req_i,
   input wire table_s table_i,
   input wire logic start_contact_i,
   input wire latch_evt_s amp_latch_i,
   input wire logic latch_wait_o,
   input wire logic armed_o,
   input wire logic next_table_o,
   input wire logic [POS_W-1:0] latch_pos_o,
   input wire logic error_stop_o,
   input wire logic [15:0] error_code_o,
   input wire logic [POS_W-1:0] mon_speed_o,
   input wire logic mon_valid_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   int cnt;
   wire spd = table_i.active && table_i.pattern == PAT_SPEED;
   wire cap = amp_latch_i.valid && latch_wait_o && spd;
   // Parked above the delay so only a fresh capture starts the count.
   always_ff @(posedge sys_clk_i)
      cnt <= (sys_rst_i || !armed_o || error_stop_o) ? START_DELAY_CYC + 1 :
         cap ? 0 : (cnt <= START_DELAY_CYC) ? cnt + 1 : cnt;
   property p_wait; $rose(latch_wait_o) |-> $past(latch_req_i); endproperty
   a_wait: assert property (p_wait) else $error("wait no req");
   property p_drop; !latch_req_i [*2] |=> !armed_o; endproperty
   a_drop: assert property (p_drop) else $error("still armed");
   property p_cap;
      cap |=> latch_pos_o == $past(amp_latch_i.position) && !latch_wait_o;
   endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   property p_unarmed;
      $rose(start_contact_i) && spd && !armed_o && !latch_req_i
         |=> next_table_o;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("no start");
   property p_delay;
      next_table_o && $past(armed_o) |-> cnt == START_DELAY_CYC;
   endproperty
   a_delay: assert property (p_delay) else $error("early start");
   property p_fire; cnt == START_DELAY_CYC |-> next_table_o; endproperty
   a_fire: assert property (p_fire) else $error("late start");
   property p_err; amp_latch_i.valid && latch_req_i && cnt < START_DELAY_CYC
      |=> error_stop_o && error_code_o == ERR_MULTI_LATCH; endproperty
   a_err: assert property (p_err) else $error("no error");
   property p_mon;
      (armed_o && spd) [*3] |-> !mon_valid_o && mon_speed_o == '0;
   endproperty
   a_mon: assert property (p_mon) else $error("monitor shown");
   cover property (cnt == START_DELAY_CYC);
   cover property (error_stop_o);
   cover property ($fell(latch_wait_o));
endmodule : latch_pt_checker
bind latch_speed_point_ctrl latch_pt_checker chk_u (.*);

// File: sim/amp_model.sv
// Servo amplifier model that reports latch events.
`timescale 1ns/1ps
module amp_model
   import latch_pt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic hit_i,
   input wire logic [POS_W-1:0] pos_i,
   output latch_evt_s evt_o
);
   // Position reads inverted between events so a stale value is never trusted.
   always @(posedge sys_clk_i)
      evt_o <= hit_i ? {1'b1, pos_i} : {1'b0, ~pos_i};
endmodule : amp_model

// File: sim/latch_speed_point_ctrl_bench.sv
// Bench for the latch-corrected speed-point control.
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module latch_speed_point_ctrl_bench import latch_pt_pkg::*; ;
   logic clk = 0, rst = 1, req = 0, st = 0, dn = 0, con = 0, hit = 0;
   logic lw, arm, nt, lpv, es, mv;
   logic [POS_W-1:0] pos = '0, lp, ms, mt;
   logic [15:0] ec;
   table_s tbl = '0;
   latch_evt_s evt;
   int err_total = 0, samples_checked = 0, k;
   always #12.5 clk = ~clk;
   amp_model amp_u (.sys_clk_i(clk), .hit_i(hit), .pos_i(pos), .evt_o(evt));
   latch_speed_point_ctrl dut_u (.sys_clk_i(clk), .sys_rst_i(rst),
      .latch_req_i(req), .op_start_i(st), .op_done_i(dn), .table_i(tbl),
      .start_contact_i(con), .amp_latch_i(evt), .mon_speed_i(32'h0000_0055),
      .mon_torque_i(32'h0000_0066), .latch_wait_o(lw), .armed_o(arm),
      .next_table_o(nt), .latch_pos_o(lp), .latch_pos_valid_o(lpv),
      .error_stop_o(es), .error_code_o(ec), .mon_speed_o(ms),
      .mon_torque_o(mt), .mon_valid_o(mv));
   task automatic step(int n); repeat (n) @(negedge clk); endtask : step
   task automatic results;
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic poll(ref logic s, input int lim, output int n);
      for (n = 0; n < lim && s !== 1'b1; n++) step(1);
      `CHK("poll", 1'b1, s)
      if (s !== 1'b1) results();
   endtask : poll
   task automatic latch(logic [POS_W-1:0] p);
      pos = p;
      hit = 1;
      step(1);
      hit = 0;
   endtask : latch
   initial begin
      step(2);
      rst = 0;
      tbl = '{1'b1, PAT_SPEED};
      con = 1;
      poll(nt, 3, k);
      `CHK("mon shown", 1'b1, mv)
      `CHK("mon speed", 32'h0000_0055, ms)
      `CHK("mon torque", 32'h0000_0066, mt)
      con = 0;
      req = 1;
      poll(lw, 4, k);
      st = 1;
      con = 1;
      step(1);
      st = 0;
      repeat (4) begin
         step(1);
         `CHK("contact", 1'b0, nt)
      end
      `CHK("mon valid", 1'b0, mv)
      `CHK("mon speed", 32'h0000_0000, ms)
      `CHK("mon torque", 32'h0000_0000, mt)
      con = 0;
      latch(32'h0001_2345);
      poll(lpv, 4, k);
      `CHK("pos", 32'h0001_2345, lp)
      `CHK("wait off", 1'b0, lw)
      poll(nt, 40010, k);
      `CHK("delay", START_DELAY_CYC, k)
      dn = 1;
      step(1);
      `CHK("pulse", 1'b0, nt)
      dn = 0;
      poll(lw, 3, k);
      st = 1;
      step(1);
      st = 0;
      latch(32'h0000_0A0A);
      step(3);
      latch(32'h0000_0B0B);
      poll(es, 4, k);
      `CHK("code", ERR_MULTI_LATCH, ec)
      `CHK("held pos", 32'h0000_0A0A, lp)
      st = 1;
      step(1);
      st = 0;
      step(2);
      `CHK("code clr", ERR_NONE, ec)
      `CHK("stop clr", 1'b0, es)
      `CHK("pos valid clr", 1'b0, lpv)
      req = 0;
      step(3);
      `CHK("disarm", 1'b0, arm)
      con = 1;
      poll(nt, 3, k);
      results();
   end
endmodule : latch_speed_point_ctrl_bench
